// [rtl/dmar_cfg.svh]
// Purpose: Offsets, field positions and reset values of the reload DMA channel.
// Assumes: AXI4-Lite register window with one 32-bit word per register.
// Notes:   Definitions only.
`ifndef DMAR_CFG_SVH
`define DMAR_CFG_SVH
`define DMAR_OFF_SRC     8'h00
`define DMAR_OFF_DST     8'h04
`define DMAR_OFF_CNT     8'h08
`define DMAR_OFF_CTRL    8'h0C
`define DMAR_OFF_STAT    8'h10
`define DMAR_CTRL_EN     0
`define DMAR_CTRL_RLD    1
`define DMAR_CTRL_IE     2
`define DMAR_CTRL_BURST  3
`define DMAR_CTRL_SINC   4
`define DMAR_CTRL_DINC   5
`define DMAR_CTRL_SZ_LO  6
`define DMAR_STAT_TE     0
`define DMAR_STAT_BUSY   1
`define DMAR_STAT_GRP_LO 2
`define DMAR_RST_WORD    32'h0000_0000
`define DMAR_RST_CTRL    8'h00
`define DMAR_GRP_LAST    2'h3
`define DMAR_FIFO_DEPTH  32
`define DMAR_RESP_OKAY   2'h0
`define DMAR_RESP_SLVERR 2'h2
`endif

// [rtl/dmar_pkg.sv]
// Purpose: Types shared by the reload DMA channel.
// Assumes: Constants live in dmar_cfg.svh.
// Notes:   None.
package dmar_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_GRANT, ST_RD, ST_WR} dmar_state_e;
  typedef logic [31:0] dmar_word_t;
  typedef logic [1:0]  dmar_size_t;
endpackage

// [rtl/dmar_channel.sv]
// Purpose: One DMA channel with address reload, AXI4-Lite registers and a data FIFO.
// Assumes: Requester, arbiter and memory port run on clk_i.
// Notes:   Reload groups are four transfers; the count should be a multiple of four.
// Functional notes
// RQ1: Reload restores source pointer every four transfers.
// RQ2: Without reload source pointer keeps advancing.
// RQ3: Reload group end halts channel, drops bus request.
// RQ4: Burst mode keeps bus between transfers.
// RQ5: Destination pointer always advances as programmed.
// RQ6: Count decrements every transfer regardless of reload.
// RQ7: End interrupt only at count zero with enable.
// RQ8: Request flag cleared at reload halt and end.
// RQ9: Peripheral re-requests before next group of four.
// RQ10: Software should choose burst mode with reload.
// RQ11: Software should program count multiple of four.
// RQ12: Byte incrementing source advances by one.
// RQ13: Count zero sets end flag, interrupts if enabled.
// RQ14: Source captured into shadow when channel enabled.
//
// The register offsets and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`include "dmar_cfg.svh"

module dmar_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   lvl;
  } dmar_fifo_s;
  dmar_fifo_s s_q, s_d;
  logic push, pop;

  assign in_ready_o  = s_q.lvl != (AW+1)'(DEPTH);
  assign out_valid_o = s_q.lvl != '0;
  assign out_data_o  = mem[s_q.rp];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_ready_i && out_valid_o;

  always_comb begin
    s_d = s_q;
    if (push) s_d.wp = s_q.wp + 1'b1;
    if (pop) s_d.rp = s_q.rp + 1'b1;
    s_d.lvl = s_q.lvl + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) s_q <= '0;
    else s_q <= s_d;
  end

  // Storage has no reset so it maps to plain RAM.
  always_ff @(posedge clk_i) begin
    if (push) mem[s_q.wp] <= in_data_i;
  end
endmodule

module dmar_channel (
  input  wire logic               clk_i,
  input  wire logic               reset_n_i,
  input  wire logic [7:0]         s_axi_awaddr_i,
  input  wire logic               s_axi_awvalid_i,
  output logic                    s_axi_awready_o,
  input  wire dmar_pkg::dmar_word_t s_axi_wdata_i,
  input  wire logic [3:0]         s_axi_wstrb_i,
  input  wire logic               s_axi_wvalid_i,
  output logic                    s_axi_wready_o,
  output logic [1:0]              s_axi_bresp_o,
  output logic                    s_axi_bvalid_o,
  input  wire logic               s_axi_bready_i,
  input  wire logic [7:0]         s_axi_araddr_i,
  input  wire logic               s_axi_arvalid_i,
  output logic                    s_axi_arready_o,
  output dmar_pkg::dmar_word_t    s_axi_rdata_o,
  output logic [1:0]              s_axi_rresp_o,
  output logic                    s_axi_rvalid_o,
  input  wire logic               s_axi_rready_i,
  input  wire logic               xfer_req_i,
  output logic                    req_flag_clr_o,
  output logic                    bus_req_o,
  input  wire logic               bus_grant_i,
  output logic                    mem_req_o,
  output logic                    mem_we_o,
  output dmar_pkg::dmar_word_t    mem_addr_o,
  output dmar_pkg::dmar_size_t    mem_size_o,
  output dmar_pkg::dmar_word_t    mem_wdata_o,
  input  wire logic               mem_ack_i,
  input  wire dmar_pkg::dmar_word_t mem_rdata_i,
  output logic                    end_irq_o
);
  import dmar_pkg::*;

  typedef struct packed {
    dmar_state_e st;
    dmar_word_t  src;
    dmar_word_t  dst;
    dmar_word_t  cnt;
    dmar_word_t  shadow;
    logic [7:0]  ctrl;
    logic        te;
    logic [1:0]  grp;
    logic        bus_req;
    logic        mem_req;
    logic        mem_we;
    dmar_word_t  mem_addr;
    dmar_word_t  mem_wdata;
    logic        flag_clr;
    logic        irq;
    logic        aw_full;
    logic [7:0]  awaddr;
    logic        w_full;
    dmar_word_t  wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    dmar_word_t  rdata;
    logic [1:0]  rresp;
  } dmar_state_s;

  dmar_state_s s_q, s_d;
  logic        fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  dmar_word_t  fifo_out_data;
  logic        xfer_done, last_xfer, group_halt;
  dmar_word_t  step;

  function automatic dmar_word_t merge(dmar_word_t old, dmar_word_t nw, logic [3:0] be);
    dmar_word_t r;
    r = old;
    for (int i = 0; i < 4; i++) if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  dmar_fifo #(.WIDTH(32), .DEPTH(`DMAR_FIFO_DEPTH)) u_fifo (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (mem_rdata_i),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );

  assign step       = 32'h1 << s_q.ctrl[`DMAR_CTRL_SZ_LO +: 2]; // [RQ12]
  assign xfer_done  = s_q.st == ST_WR && s_q.mem_req && mem_ack_i;
  assign last_xfer  = s_q.cnt == 32'h1;
  // The last group reloads as well, so with a count that is a multiple of four the source ends on its start value.
  assign group_halt = xfer_done && s_q.ctrl[`DMAR_CTRL_RLD]
                      && s_q.grp == `DMAR_GRP_LAST;
  // The read is only launched with room in the FIFO, so its ack always lands.
  assign fifo_in_valid  = s_q.st == ST_RD && s_q.mem_req && mem_ack_i;
  assign fifo_out_ready = s_q.st == ST_WR && !s_q.mem_req;

  always_comb begin
    logic do_wr;
    do_wr = 1'b0;
    s_d = s_q;
    s_d.flag_clr = 1'b0;
    // Register writes: address and data may arrive in either order.
    if (s_axi_awvalid_i && s_q.awready) begin
      s_d.aw_full = 1'b1;
      s_d.awaddr  = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_q.wready) begin
      s_d.w_full = 1'b1;
      s_d.wdata  = s_axi_wdata_i;
      s_d.wstrb  = s_axi_wstrb_i;
    end
    if (s_q.bvalid && s_axi_bready_i) s_d.bvalid = 1'b0;
    if (s_q.aw_full && s_q.w_full && !s_q.bvalid) begin
      do_wr      = 1'b1;
      s_d.aw_full = 1'b0;
      s_d.w_full  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = `DMAR_RESP_OKAY;
      case (s_q.awaddr)
        `DMAR_OFF_SRC: s_d.src = merge(s_q.src, s_q.wdata, s_q.wstrb);
        `DMAR_OFF_DST: s_d.dst = merge(s_q.dst, s_q.wdata, s_q.wstrb);
        `DMAR_OFF_CNT: s_d.cnt = merge(s_q.cnt, s_q.wdata, s_q.wstrb);
        `DMAR_OFF_CTRL: begin
          if (s_q.wstrb[0]) s_d.ctrl = s_q.wdata[7:0];
          if (s_q.wstrb[0] && s_q.wdata[`DMAR_CTRL_EN] && !s_q.ctrl[`DMAR_CTRL_EN]) begin
            s_d.shadow = s_q.src; // [RQ14]
          end
        end
        `DMAR_OFF_STAT: begin
          if (s_q.wstrb[0] && s_q.wdata[`DMAR_STAT_TE]) s_d.te = 1'b0;
        end
        default: s_d.bresp = `DMAR_RESP_SLVERR;
      endcase
    end
    // Register reads answer one cycle after the address is taken.
    if (s_q.rvalid && s_axi_rready_i) s_d.rvalid = 1'b0;
    if (s_axi_arvalid_i && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = `DMAR_RESP_OKAY;
      case (s_axi_araddr_i)
        `DMAR_OFF_SRC:  s_d.rdata = s_q.src;
        `DMAR_OFF_DST:  s_d.rdata = s_q.dst;
        `DMAR_OFF_CNT:  s_d.rdata = s_q.cnt;
        `DMAR_OFF_CTRL: s_d.rdata = {24'h000000, s_q.ctrl};
        `DMAR_OFF_STAT: s_d.rdata = {28'h0000000, s_q.grp, s_q.st != ST_IDLE, s_q.te};
        default: begin
          s_d.rdata = 32'h0000_0000;
          s_d.rresp = `DMAR_RESP_SLVERR;
        end
      endcase
    end
    // Transfer engine.
    case (s_q.st)
      ST_IDLE: begin
        // The peripheral's flag falls only after it sees the clear pulse, so a
        // request seen alongside the pulse is stale and must not start a group.
        if (s_q.ctrl[`DMAR_CTRL_EN] && s_q.cnt != 32'h0 && xfer_req_i && !do_wr
            && !s_q.flag_clr) begin
          s_d.bus_req = 1'b1;
          s_d.st      = ST_GRANT;
        end
      end
      ST_GRANT: begin
        if (bus_grant_i) s_d.st = ST_RD;
      end
      ST_RD: begin
        if (!s_q.mem_req && fifo_in_ready) begin
          s_d.mem_req  = 1'b1;
          s_d.mem_we   = 1'b0;
          s_d.mem_addr = s_q.src;
        end else if (s_q.mem_req && mem_ack_i) begin
          s_d.mem_req = 1'b0;
          s_d.st      = ST_WR;
        end
      end
      ST_WR: begin
        if (!s_q.mem_req && fifo_out_valid) begin
          s_d.mem_req   = 1'b1;
          s_d.mem_we    = 1'b1;
          s_d.mem_addr  = s_q.dst;
          s_d.mem_wdata = fifo_out_data;
        end else if (xfer_done) begin
          s_d.mem_req = 1'b0;
          s_d.mem_we  = 1'b0;
          s_d.cnt     = s_q.cnt - 32'h1; // [RQ6]
          s_d.grp     = s_q.grp + 2'h1;
          if (s_q.ctrl[`DMAR_CTRL_DINC]) s_d.dst = s_q.dst + step; // [RQ5]
          if (group_halt) s_d.src = s_q.shadow; // [RQ1]
          else if (s_q.ctrl[`DMAR_CTRL_SINC]) s_d.src = s_q.src + step; // [RQ2] [RQ12]
          if (last_xfer) begin
            s_d.te = 1'b1; // [RQ13]
            s_d.ctrl[`DMAR_CTRL_EN] = 1'b0;
            s_d.grp = 2'h0;
          end
          if (last_xfer || group_halt) begin
            s_d.flag_clr = 1'b1; // [RQ8]
            s_d.bus_req  = 1'b0; // [RQ3]
            s_d.st       = ST_IDLE;
          end else if (s_q.ctrl[`DMAR_CTRL_BURST] || s_q.ctrl[`DMAR_CTRL_RLD]) begin
            s_d.st = ST_RD; // [RQ4]
          end else begin
            s_d.bus_req = 1'b0;
            s_d.st      = ST_IDLE;
          end
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    // Software clearing the enable drops a request still waiting in ST_GRANT without setting the end flag; ST_RD and ST_WR run on.
    if (!s_d.ctrl[`DMAR_CTRL_EN] && s_q.st == ST_GRANT) begin
      s_d.bus_req = 1'b0;
      s_d.st      = ST_IDLE;
    end
    s_d.irq     = s_d.te && s_d.ctrl[`DMAR_CTRL_IE]; // [RQ7]
    s_d.awready = !s_d.aw_full;
    s_d.wready  = !s_d.w_full;
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q         <= '0;
      s_q.st      <= ST_IDLE;
      s_q.ctrl    <= `DMAR_RST_CTRL;
      s_q.src     <= `DMAR_RST_WORD;
      s_q.dst     <= `DMAR_RST_WORD;
      s_q.cnt     <= `DMAR_RST_WORD;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready_o = s_q.awready;
  assign s_axi_wready_o  = s_q.wready;
  assign s_axi_bvalid_o  = s_q.bvalid;
  assign s_axi_bresp_o   = s_q.bresp;
  assign s_axi_arready_o = s_q.arready;
  assign s_axi_rvalid_o  = s_q.rvalid;
  assign s_axi_rdata_o   = s_q.rdata;
  assign s_axi_rresp_o   = s_q.rresp;
  assign req_flag_clr_o  = s_q.flag_clr;
  assign bus_req_o       = s_q.bus_req;
  assign mem_req_o       = s_q.mem_req;
  assign mem_we_o        = s_q.mem_we;
  assign mem_addr_o      = s_q.mem_addr;
  assign mem_size_o      = s_q.ctrl[`DMAR_CTRL_SZ_LO +: 2];
  assign mem_wdata_o     = s_q.mem_wdata;
  assign end_irq_o       = s_q.irq;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence seq_done;
    xfer_done && !last_xfer;
  endsequence
  sequence seq_halt;
    group_halt;
  endsequence

  a_reload_src_restore: assert property (seq_halt |=> s_q.src == $past(s_q.shadow)) // [RQ1]
    else $error("Source pointer not restored at reload.");
  a_noreload_src_adv: assert property ( // [RQ2]
      seq_done ##0 (!s_q.ctrl[`DMAR_CTRL_RLD] && s_q.ctrl[`DMAR_CTRL_SINC])
      |=> s_q.src == $past(s_q.src) + $past(step))
    else $error("Source pointer did not advance.");
  a_halt_bus_drop: assert property ( // [RQ3]
      seq_halt |=> !bus_req_o && req_flag_clr_o ##1 !bus_req_o)
    else $error("Bus request held after reload halt.");
  a_burst_bus_kept: assert property ( // [RQ4]
      seq_done ##0 (s_q.ctrl[`DMAR_CTRL_BURST] && !group_halt) |=> bus_req_o[*2])
    else $error("Bus released inside a burst.");
  a_dst_advance: assert property ( // [RQ5]
      xfer_done && s_q.ctrl[`DMAR_CTRL_DINC] |=> s_q.dst == $past(s_q.dst) + $past(step))
    else $error("Destination pointer did not advance.");
  a_count_dec: assert property (xfer_done |=> s_q.cnt == $past(s_q.cnt) - 32'h1) // [RQ6]
    else $error("Count not decremented.");
  a_irq_end_only: assert property ( // [RQ7]
      $rose(end_irq_o) |-> s_q.te && s_q.ctrl[`DMAR_CTRL_IE])
    else $error("End interrupt without end flag.");
  a_flag_clr_cause: assert property ( // [RQ8]
      req_flag_clr_o |-> $past(group_halt) || $past(xfer_done && last_xfer))
    else $error("Request flag cleared mid-sequence.");
  a_te_at_zero: assert property ( // [RQ13]
      xfer_done && last_xfer |=> s_q.te && s_q.cnt == 32'h0 ##1 !bus_req_o)
    else $error("End flag not set at count zero.");
  a_shadow_take: assert property ( // [RQ14]
      $rose(s_q.ctrl[`DMAR_CTRL_EN]) |-> s_q.shadow == $past(s_q.src))
    else $error("Shadow not captured at enable.");
endmodule

// [verification/dmar_far_model.sv]
// Purpose: Bus arbiter and memory port facing the reload DMA channel.
// Assumes: One clock; slow_i adds two wait cycles to each grant and ack.
// Notes:   Read data is one random byte in all lanes; idle data toggles.
`timescale 1ns/1ps
module dmar_far_model (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        slow_i,
  input  wire logic        bus_req_i,
  output logic             bus_grant_o,
  input  wire logic        mem_req_i,
  output logic             mem_ack_o,
  output logic [31:0]      mem_rdata_o
);
  logic [1:0] gcnt_q;
  logic [1:0] acnt_q;
  always @(posedge clk_i or negedge reset_n_i) begin
    logic [7:0] b;
    if (!reset_n_i) begin
      bus_grant_o <= 1'h0;
      gcnt_q      <= 2'h0;
      acnt_q      <= 2'h0;
      mem_ack_o   <= 1'h0;
      mem_rdata_o <= 32'h0;
    end else begin
      b = 8'($urandom);
      gcnt_q      <= bus_req_i ? ((gcnt_q == 2'h3) ? gcnt_q : gcnt_q + 2'h1) : 2'h0;
      bus_grant_o <= bus_req_i && (!slow_i || gcnt_q >= 2'h2);
      mem_ack_o   <= 1'h0;
      // Stale data must never look valid, so idle lanes flip every cycle.
      mem_rdata_o <= ~mem_rdata_o;
      if (mem_req_i && !mem_ack_o) begin
        acnt_q <= acnt_q + 2'h1;
        if (!slow_i || acnt_q == 2'h2) begin
          mem_ack_o   <= 1'h1;
          acnt_q      <= 2'h0;
          mem_rdata_o <= {b, b, b, b};
        end
      end
    end
  end
endmodule

// [verification/tb_dma_channel_address_reload.sv]
// Purpose: Self-checking bench of the reload DMA channel.
// Assumes: Byte transfers, incrementing pointers, burst mode.
// Notes:   A reference model tracks the expected pointers per transfer.
`timescale 1ns/1ps
`include "dmar_cfg.svh"
module tb_dma_channel_address_reload;
  import dmar_pkg::*;
  logic       clk = 1'h0, rst_n = 1'h0, xreq = 1'h0, slow = 1'h0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic       awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  dmar_word_t wdata = 32'h0;
  logic       awready, wready, bvalid, arready, rvalid, clr, breq, grant, mreq, mwe, ack, irq;
  logic [1:0] bresp, rresp;
  dmar_size_t msize;
  dmar_word_t rdata, maddr, mwdata, mrdata, exp_src, exp_dst;
  logic [7:0] rbyte;
  logic       rld_m, breq_q = 1'h0;
  int         mismatches = 0, cmp_count = 0, cyc = 0, k = 0, clr_n = 0, fall_n = 0;

  always #2 clk = ~clk;

  dmar_channel dut_u (.clk_i(clk), .reset_n_i(rst_n),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .xfer_req_i(xreq),
    .req_flag_clr_o(clr), .bus_req_o(breq), .bus_grant_i(grant), .mem_req_o(mreq),
    .mem_we_o(mwe), .mem_addr_o(maddr), .mem_size_o(msize), .mem_wdata_o(mwdata),
    .mem_ack_i(ack), .mem_rdata_i(mrdata), .end_irq_o(irq));

  dmar_far_model far_u (.clk_i(clk), .reset_n_i(rst_n), .slow_i(slow),
    .bus_req_i(breq), .bus_grant_o(grant), .mem_req_i(mreq), .mem_ack_o(ack),
    .mem_rdata_o(mrdata));

  task give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task axi_wr(input logic [7:0] a, input dmar_word_t d, output logic [1:0] r);
    logic aw_p, w_p;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    aw_p = 1'h1;
    w_p  = 1'h1;
    while (aw_p || w_p) begin
      @(posedge clk);
      if (aw_p && awready) begin
        aw_p = 1'h0;
        awvalid <= 1'h0;
      end
      if (w_p && wready) begin
        w_p = 1'h0;
        wvalid <= 1'h0;
      end
    end
    while (!bvalid) @(posedge clk);
    r = bresp;
    bready <= 1'h0;
  endtask

  task axi_rd(input logic [7:0] a, output dmar_word_t d, output logic [1:0] r);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'h0;
    while (!rvalid) @(posedge clk);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask

  task wr(input logic [7:0] a, input dmar_word_t d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk({30'h0, r}, {30'h0, `DMAR_RESP_OKAY});
  endtask

  task rd_chk(input logic [7:0] a, input dmar_word_t e);
    dmar_word_t d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(d, e);
  endtask

  task wait_clr(input int n);
    for (int i = 0; i < 2000 && clr_n < n; i++) begin
      @(posedge clk);
      #1;
    end
    // A clear pulse that never comes counts as a failure.
    if (clr_n < n) mismatches++;
  endtask

  // Reference model: every completed write advances the expected destination; the source advances, or restarts every fourth write with reload.
  always @(posedge clk) begin
    breq_q <= breq;
    if (breq_q && !breq) fall_n++;
    if (clr) begin
      clr_n++;
      xreq <= 1'h0;
    end
    if (mreq && ack && !mwe) begin
      chk(maddr, exp_src);
      chk({30'h0, msize}, 32'h0);
      rbyte = mrdata[7:0];
    end else if (mreq && ack) begin
      chk(maddr, exp_dst);
      chk({24'h0, mwdata[7:0]}, {24'h0, rbyte});
      k++;
      exp_dst++;
      exp_src = (rld_m && k % 4 == 0) ? 32'hFFFF83F0 : exp_src + 32'h1;
    end
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  task run_case(input logic rld, input logic ie);
    int base;
    dmar_word_t d;
    logic [1:0] r;
    k = 0;
    exp_src = 32'hFFFF83F0;
    exp_dst = 32'hFFFFF000;
    rld_m = rld;
    base = clr_n;
    fall_n = 0;
    slow <= 1'($urandom);
    wr(`DMAR_OFF_SRC, 32'hFFFF83F0);
    wr(`DMAR_OFF_DST, 32'hFFFFF000);
    wr(`DMAR_OFF_CNT, 32'h8);
    wr(`DMAR_OFF_CTRL, {26'h0, 3'h7, ie, rld, 1'h1});
    for (int g = 0; g < (rld ? 2 : 1); g++) begin
      @(posedge clk);
      xreq <= 1'h1;
      wait_clr(base + g + 1);
      if (rld && g == 0) begin
        rd_chk(`DMAR_OFF_SRC, 32'hFFFF83F0);
        rd_chk(`DMAR_OFF_DST, 32'hFFFFF004);
        rd_chk(`DMAR_OFF_CNT, 32'h4);
        chk({31'h0, breq}, 32'h0);
        chk({31'h0, irq}, 32'h0);
      end
    end
    rd_chk(`DMAR_OFF_SRC, rld ? 32'hFFFF83F0 : 32'hFFFF83F8);
    rd_chk(`DMAR_OFF_DST, 32'hFFFFF008);
    rd_chk(`DMAR_OFF_CNT, 32'h0);
    chk({31'h0, irq}, {31'h0, ie});
    axi_rd(`DMAR_OFF_STAT, d, r);
    chk({31'h0, d[`DMAR_STAT_TE]}, 32'h1);
    chk(fall_n, rld ? 32'h2 : 32'h1);
    chk(clr_n - base, rld ? 32'h2 : 32'h1);
    wr(`DMAR_OFF_STAT, 32'h1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
  endtask

  initial begin
    dmar_word_t d;
    logic [1:0] r;
    void'($urandom(75));
    repeat (12) @(posedge clk);
    rst_n <= 1'h1;
    rd_chk(`DMAR_OFF_CTRL, 32'h0);
    axi_rd(8'h14, d, r);
    chk({30'h0, r}, {30'h0, `DMAR_RESP_SLVERR});
    chk(d, 32'h0);
    axi_wr(8'h14, 32'hFFFFFFFF, r);
    chk({30'h0, r}, {30'h0, `DMAR_RESP_SLVERR});
    run_case(1'h1, 1'h1);
    run_case(1'h0, 1'h0);
    give_verdict();
  end
endmodule
